//--- inc/uvf_pkg.sv
// Shared constants, carriers and the Linear-11 decoder of the undervoltage fault block.
// Assumes a 250 MHz core clock and a byte-coded command path from the management bus.
package uvf_pkg;
    // Command codes
    localparam logic [7:0] UVF_CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] UVF_CMD_WARN_LIMIT = 8'h58;
    localparam logic [7:0] UVF_CMD_FAULT_THRESHOLD = 8'h59;
    localparam logic [7:0] UVF_CMD_FAULT_ACTION = 8'h5a;
    localparam logic [7:0] UVF_CMD_STATUS_INPUT = 8'h7c;
    // Reset values and field layout of the fault action byte
    localparam logic [7:0] UVF_ACTION_RESET = 8'hbf;
    localparam int UVF_RESP_MSB = 7;
    localparam int UVF_RESP_LSB = 6;
    localparam int UVF_RETRY_MSB = 5;
    localparam int UVF_RETRY_LSB = 3;
    localparam int UVF_DELAY_MSB = 2;
    localparam int UVF_DELAY_LSB = 0;
    localparam logic [1:0] UVF_RESP_DISABLE_RETRY = 2'h2;
    localparam logic [1:0] UVF_RESP_WHILE_FAULT = 2'h3;
    localparam logic [2:0] UVF_RETRY_NONE = 3'h0;
    localparam logic [2:0] UVF_RETRY_CONTINUOUS = 3'h7;
    localparam int UVF_STATUS_UV_BIT = 4;
    // Warning limit default is strap times 11 over 10
    localparam logic [27:0] UVF_WARN_NUM = 28'h000000b;
    localparam logic [27:0] UVF_WARN_DEN = 28'h000000a;
    // Strap settle count after reset release (covers the two-flop synchroniser)
    localparam logic [1:0] UVF_STRAP_SETTLE = 2'h3;
    // Retry time unit
    localparam int UVF_RETRY_UNIT_MS = 35;
    localparam int UVF_CLOCK_KHZ = 250000;
    localparam int UVF_RETRY_UNIT_CYCLES = UVF_RETRY_UNIT_MS * UVF_CLOCK_KHZ;

    typedef struct packed {
        logic write;
        logic [7:0] code;
        logic [15:0] data;
    } uvf_req_t;

    typedef struct packed {
        logic [15:0] data;
        logic refused;
    } uvf_ans_t;

    // Linear-11 to unsigned volts with 8 fraction bits; negatives read as zero, overflow saturates
    function automatic logic [23:0] uvf_l11_fix(input logic [15:0] code);
        logic signed [4:0] n;
        logic signed [5:0] m;
        logic [39:0] t;
        logic [23:0] r;
        n = signed'(code[15:11]);
        m = -{n[4], n};
        t = {22'h0, code[9:0], 8'h00};
        r = 24'h0;
        if (code[10]) begin
            r = 24'h0;
        end else if (n >= 0) begin
            t = t << n[3:0];
            r = (|t[39:24]) ? 24'hffffff : t[23:0];
        end else begin
            t = t >> m[4:0];
            r = t[23:0];
        end
        return r;
    endfunction
endpackage

//--- logic/uvf_sync.sv
// Two-flop synchroniser for levels entering the domain of clock.
// Assumes each bit is a level that holds for several clock periods.
module uvf_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_one;

    // First stage feeds only the second
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            stage_one <= '0;
            sync_out <= '0;
        end else begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end
endmodule // uvf_sync

//--- logic/uvf_link_port.sv
// Command port on the management link clock; passes one request at a time to the core.
// Assumes the core answers each request toggle with one answer toggle and stable answer data.
module uvf_link_port
    import uvf_pkg::*;
(
    input wire logic link_clock,
    input wire logic reset,
    input wire logic link_req_valid,
    input wire uvf_req_t link_req,
    output logic link_busy,
    output logic link_ans_valid,
    output uvf_ans_t link_ans,
    output uvf_req_t req_hold,
    output logic req_toggle,
    input wire logic ans_toggle,
    input wire uvf_ans_t ans_hold
);
    logic ans_toggle_s;
    logic ans_toggle_d;
    logic next_busy;
    logic next_ans_valid;
    logic next_req_toggle;
    uvf_ans_t next_ans;
    uvf_req_t next_req_hold;

    uvf_sync #(.WIDTH(1)) u_ans_sync (
        .clock(link_clock),
        .reset(reset),
        .async_in(ans_toggle),
        .sync_out(ans_toggle_s)
    );

    // Accept when idle, finish on the answer toggle edge
    always_comb begin
        next_busy = link_busy;
        next_req_toggle = req_toggle;
        next_req_hold = req_hold;
        next_ans = link_ans;
        next_ans_valid = 1'b0;
        if (link_busy && (ans_toggle_s != ans_toggle_d)) begin
            next_busy = 1'b0;
            next_ans = ans_hold;
            next_ans_valid = 1'b1;
        end else if (!link_busy && link_req_valid) begin
            next_busy = 1'b1;
            next_req_hold = link_req;
            next_req_toggle = !req_toggle;
        end
    end

    // Link-side registers
    always_ff @(posedge link_clock or posedge reset) begin
        if (reset) begin
            link_busy <= 1'b0;
            link_ans_valid <= 1'b0;
            link_ans <= '0;
            req_hold <= '0;
            req_toggle <= 1'b0;
            ans_toggle_d <= 1'b0;
        end else begin
            link_busy <= next_busy;
            link_ans_valid <= next_ans_valid;
            link_ans <= next_ans;
            req_hold <= next_req_hold;
            req_toggle <= next_req_toggle;
            ans_toggle_d <= ans_toggle_s;
        end
    end
endmodule // uvf_link_port

//--- logic/uvf_fault_handler.sv
// Input undervoltage fault handler: threshold, action byte, sticky status, alert and retry control.
// Assumes vin_measured, operation_on and other_fault_shutdown come from logic on clock;
// pins and the link request toggle are synchronised here.
// Overview of operation
// - Fault threshold is one global 16-bit Linear-11 read/write value, 0 to 19V.
// - After reset the fault threshold loads from the lockout strap value.
// - Action byte is global read/write, resets to bf: continuous retry, 280ms.
// - A fault drives the alert low and sets a sticky status bit until clear-faults.
// - Response 00/01 unused; 10 disables output and follows the retry field.
// - Response 11 disables output only until input rises above the warning limit.
// - Retry code 000 keeps output off until faults are cleared.
// - Retry 001-110 unused; 111 retries until commanded off or another fault.
// - Continuous retry starts only once input is above the warning limit.
// - Retry attempts are spaced by (delay field plus one) times 35ms.
// - Threshold and action writes are refused while write protection is on.
// - Warning limit is global Linear-11, defaulting to 1.10 times the strap.
module uvf_fault_handler
    import uvf_pkg::*;
#(
    parameter int unsigned RETRY_UNIT_CYCLES = UVF_RETRY_UNIT_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic link_clock,
    input wire logic link_req_valid,
    input wire uvf_req_t link_req,
    output logic link_busy,
    output logic link_ans_valid,
    output uvf_ans_t link_ans,
    input wire logic [15:0] vin_measured,
    input wire logic [15:0] undervoltage_lockout_strap,
    input wire logic enable_pin,
    input wire logic write_protect,
    input wire logic operation_on,
    input wire logic other_fault_shutdown,
    output logic output_enable,
    output logic alert_line_out,
    output logic alert_line_oe_n
);
    typedef enum {st_off, st_run, st_hold_warn, st_hold_clear, st_retry} uvf_state_t;

    uvf_state_t state, next_state;
    uvf_req_t req_hold;
    uvf_ans_t ans_hold, next_ans_hold;
    logic req_toggle, req_toggle_s, req_toggle_d, ans_toggle, next_ans_toggle;
    logic enable_s, write_protect_s;
    logic [15:0] strap_s, strap_code, next_strap_code;
    logic [1:0] settle, next_settle;
    logic [15:0] threshold, next_threshold, warn_code, next_warn_code;
    logic warn_written, next_warn_written;
    logic [7:0] action, next_action;
    logic status_uv, next_status_uv;
    logic [27:0] retry_timer, next_retry_timer;
    logic next_output_enable, next_alert_oe_n;
    logic req_seen, clear_cmd, commanded, under_fault, above_warn, fault_event;
    logic [23:0] vin_fix, threshold_fix, warn_fix;
    logic [27:0] strap_scaled;
    logic [27:0] retry_load;

    uvf_link_port u_link (
        .link_clock(link_clock),
        .reset(reset),
        .link_req_valid(link_req_valid),
        .link_req(link_req),
        .link_busy(link_busy),
        .link_ans_valid(link_ans_valid),
        .link_ans(link_ans),
        .req_hold(req_hold),
        .req_toggle(req_toggle),
        .ans_toggle(ans_toggle),
        .ans_hold(ans_hold)
    );

    uvf_sync #(.WIDTH(19)) u_pin_sync (
        .clock(clock),
        .reset(reset),
        .async_in({req_toggle, enable_pin, write_protect, undervoltage_lockout_strap}),
        .sync_out({req_toggle_s, enable_s, write_protect_s, strap_s})
    );

    // Decoded levels and conditions
    always_comb begin
        req_seen = req_toggle_s != req_toggle_d;
        clear_cmd = req_seen && req_hold.write && (req_hold.code == UVF_CMD_CLEAR_FAULTS);
        commanded = enable_s && operation_on && !other_fault_shutdown;
        vin_fix = uvf_l11_fix(vin_measured);
        threshold_fix = uvf_l11_fix(threshold);
        strap_scaled = ({4'h0, uvf_l11_fix(strap_code)} * UVF_WARN_NUM) / UVF_WARN_DEN;
        warn_fix = warn_written ? uvf_l11_fix(warn_code) : strap_scaled[23:0];
        under_fault = (settle == UVF_STRAP_SETTLE) && (vin_fix < threshold_fix);
        above_warn = vin_fix > warn_fix;
        fault_event = (state == st_run) && commanded && under_fault;
        retry_load = 28'((32'(action[UVF_DELAY_MSB:UVF_DELAY_LSB]) + 32'h1) * RETRY_UNIT_CYCLES);
    end

    // Register file: strap load, writes with protection, reads and clear-faults
    always_comb begin
        next_settle = settle;
        next_strap_code = strap_code;
        next_threshold = threshold;
        next_warn_code = warn_code;
        next_warn_written = warn_written;
        next_action = action;
        next_ans_hold = ans_hold;
        next_ans_toggle = ans_toggle;
        if (settle != UVF_STRAP_SETTLE) begin
            next_settle = settle + 2'h1;
            if (settle == UVF_STRAP_SETTLE - 2'h1) begin
                next_strap_code = strap_s;
                next_threshold = strap_s;
                next_warn_code = strap_s;
            end
        end
        if (req_seen) begin
            next_ans_toggle = !ans_toggle;
            next_ans_hold = '{data: 16'h0, refused: 1'b0};
            case (req_hold.code)
                UVF_CMD_FAULT_THRESHOLD: begin
                    if (!req_hold.write) begin
                        next_ans_hold.data = threshold;
                    end else if (write_protect_s) begin
                        next_ans_hold.refused = 1'b1;
                    end else begin
                        next_threshold = req_hold.data;
                    end
                end
                UVF_CMD_FAULT_ACTION: begin
                    if (!req_hold.write) begin
                        next_ans_hold.data = {8'h00, action};
                    end else if (write_protect_s) begin
                        next_ans_hold.refused = 1'b1;
                    end else begin
                        next_action = req_hold.data[7:0];
                    end
                end
                UVF_CMD_WARN_LIMIT: begin
                    if (!req_hold.write) begin
                        next_ans_hold.data = warn_code;
                    end else if (write_protect_s) begin
                        next_ans_hold.refused = 1'b1;
                    end else begin
                        next_warn_code = req_hold.data;
                        next_warn_written = 1'b1;
                    end
                end
                UVF_CMD_STATUS_INPUT: begin
                    next_ans_hold.refused = req_hold.write;
                    next_ans_hold.data[UVF_STATUS_UV_BIT] = status_uv;
                end
                UVF_CMD_CLEAR_FAULTS: begin
                    next_ans_hold.refused = !req_hold.write;
                end
                default: begin
                    next_ans_hold.refused = 1'b1;
                end
            endcase
        end
    end

    // Fault state machine, retry timer, sticky status and alert
    always_comb begin
        next_state = state;
        next_retry_timer = (retry_timer != 28'h0) ? retry_timer - 28'h1 : retry_timer;
        next_status_uv = (status_uv && !clear_cmd) || fault_event;
        case (state)
            st_off: begin
                if (commanded) begin
                    next_state = st_run;
                end
            end
            st_run: begin
                if (!commanded) begin
                    next_state = st_off;
                end else if (fault_event) begin
                    if (action[UVF_RESP_MSB:UVF_RESP_LSB] == UVF_RESP_WHILE_FAULT) begin
                        next_state = st_hold_warn;
                    end else if ((action[UVF_RESP_MSB:UVF_RESP_LSB] == UVF_RESP_DISABLE_RETRY) &&
                                 (action[UVF_RETRY_MSB:UVF_RETRY_LSB] == UVF_RETRY_CONTINUOUS)) begin
                        next_state = st_retry;
                        next_retry_timer = retry_load;
                    end else begin
                        next_state = st_hold_clear;
                    end
                end
            end
            st_hold_warn: begin
                if (above_warn) begin
                    next_state = st_run;
                end
            end
            st_hold_clear: begin
                if (clear_cmd) begin
                    next_state = st_run;
                end
            end
            st_retry: begin
                if (!commanded) begin
                    next_state = st_off;
                end else if ((retry_timer == 28'h0) && above_warn) begin
                    next_state = st_run;
                end
            end
            default: begin
                next_state = st_off;
            end
        endcase
        next_output_enable = (next_state == st_run);
        next_alert_oe_n = !next_status_uv;
    end

    // State registers
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state <= st_off;
            settle <= 2'h0;
            strap_code <= 16'h0;
            threshold <= 16'h0;
            warn_code <= 16'h0;
            warn_written <= 1'b0;
            action <= UVF_ACTION_RESET;
            ans_hold <= '0;
            ans_toggle <= 1'b0;
            req_toggle_d <= 1'b0;
            status_uv <= 1'b0;
            retry_timer <= 28'h0;
            output_enable <= 1'b0;
            alert_line_out <= 1'b0;
            alert_line_oe_n <= 1'b1;
        end else begin
            state <= next_state;
            settle <= next_settle;
            strap_code <= next_strap_code;
            threshold <= next_threshold;
            warn_code <= next_warn_code;
            warn_written <= next_warn_written;
            action <= next_action;
            ans_hold <= next_ans_hold;
            ans_toggle <= next_ans_toggle;
            req_toggle_d <= req_toggle_s;
            status_uv <= next_status_uv;
            retry_timer <= next_retry_timer;
            output_enable <= next_output_enable;
            alert_line_out <= 1'b0;
            alert_line_oe_n <= next_alert_oe_n;
        end
    end

    // Checks
    property p_fault_alert;
        @(posedge clock) disable iff (reset) fault_event |=> status_uv && !alert_line_oe_n && !output_enable;
    endproperty
    a_fault_alert: assert property (p_fault_alert) else $error("fault did not raise alert");

    property p_status_sticky;
        @(posedge clock) disable iff (reset) status_uv && !clear_cmd |=> status_uv;
    endproperty
    a_status_sticky: assert property (p_status_sticky) else $error("status bit lost");

    property p_wp_refuse;
        @(posedge clock) disable iff (reset) req_seen && req_hold.write && write_protect_s |=>
            $stable(threshold) && $stable(action);
    endproperty
    a_wp_refuse: assert property (p_wp_refuse) else $error("protected write landed");

    property p_hold_warn;
        @(posedge clock) disable iff (reset) state == st_hold_warn && !above_warn |=> !output_enable;
    endproperty
    a_hold_warn: assert property (p_hold_warn) else $error("output on below warning");

    property p_hold_clear;
        @(posedge clock) disable iff (reset) state == st_hold_clear && !clear_cmd |=>
            state == st_hold_clear ##0 !output_enable;
    endproperty
    a_hold_clear: assert property (p_hold_clear) else $error("left latch without clear");

    property p_retry_vin;
        @(posedge clock) disable iff (reset) state == st_retry && !above_warn |=> state != st_run;
    endproperty
    a_retry_vin: assert property (p_retry_vin) else $error("retry below warning");

    property p_retry_load;
        @(posedge clock) disable iff (reset) fault_event && next_state == st_retry |=>
            retry_timer == $past(retry_load);
    endproperty
    a_retry_load: assert property (p_retry_load) else $error("retry delay wrong");

    property p_retry_stop;
        @(posedge clock) disable iff (reset) state == st_retry && !commanded |=> state == st_off ##0 !output_enable;
    endproperty
    a_retry_stop: assert property (p_retry_stop) else $error("retry not stopped");

    property p_fault_detect;
        @(posedge clock) disable iff (reset) state == st_run && commanded && under_fault |=> state != st_run;
    endproperty
    a_fault_detect: assert property (p_fault_detect) else $error("fault missed");

    // Clear, delay and resume checks
    property p_clear_status;
        @(posedge clock) disable iff (reset) clear_cmd && !fault_event |=> !status_uv && alert_line_oe_n;
    endproperty
    a_clear_status: assert property (p_clear_status) else $error("clear-faults ignored");

    property p_retry_wait;
        @(posedge clock) disable iff (reset) state == st_retry && retry_timer != 28'h0 |=> state != st_run;
    endproperty
    a_retry_wait: assert property (p_retry_wait) else $error("restart before delay");

    property p_warn_resume;
        @(posedge clock) disable iff (reset) state == st_hold_warn && above_warn |=> output_enable;
    endproperty
    a_warn_resume: assert property (p_warn_resume) else $error("no resume above warning");

    // Scenario covers
    c_fault_seen: cover property (@(posedge clock) disable iff (reset) fault_event);
    c_retry_back: cover property (@(posedge clock) disable iff (reset) state == st_retry ##1 state == st_run);
    c_warn_back: cover property (@(posedge clock) disable iff (reset) state == st_hold_warn ##1 state == st_run);
    c_clear_back: cover property (@(posedge clock) disable iff (reset) state == st_hold_clear ##1 state == st_run);
endmodule // uvf_fault_handler

//--- test/uvf_host_model.sv
// Management host model: offers one request at a time on the link port.
// Assumes the design answers each taken request with one answer pulse on link_clock.
module uvf_host_model
    import uvf_pkg::*;
(
    input wire logic link_clock,
    input wire logic link_busy,
    input wire logic link_ans_valid,
    input wire uvf_ans_t link_ans,
    output logic link_req_valid,
    output uvf_req_t link_req
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle request lines at time zero
    initial begin
        link_req_valid = 1'b0;
        link_req = '0;
    end

    // Holds the request until an edge with busy low takes it, then waits for the answer pulse
    task automatic xfer(input uvf_req_t r, output uvf_ans_t a, output bit ok);
        int n;
        n = 0;
        @(posedge link_clock);
        link_req_valid <= 1'b1;
        link_req <= r;
        @(negedge link_clock);
        while (link_busy !== 1'b0 && n < 50) begin
            @(negedge link_clock);
            n++;
        end
        @(posedge link_clock);
        link_req_valid <= 1'b0;
        link_req <= ~r; // Released lines do not keep the old value
        while (link_ans_valid !== 1'b1 && n < 100) begin
            @(negedge link_clock);
            n++;
        end
        a = link_ans;
        ok = (n < 100);
    endtask
endmodule // uvf_host_model

//--- test/tb_uvf_fault_handler.sv
// Testbench of the undervoltage fault handler: settings, fault, retry spacing and hold modes.
// Assumes the host model of uvf_host_model.sv and a retry unit shortened to UNIT cycles.
module tb_uvf_fault_handler
    import uvf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int UNIT = 20;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic link_clock = 1'b0;
    logic link_req_valid, link_busy, link_ans_valid;
    uvf_req_t link_req;
    uvf_ans_t link_ans, a;
    logic [15:0] vin_measured, strap;
    logic enable_pin = 1'b0;
    logic write_protect = 1'b0;
    logic operation_on = 1'b1;
    logic other_fault_shutdown = 1'b0;
    logic output_enable, alert_line_out, alert_line_oe_n;
    logic [7:0] spaced [3] = '{8'hb8, 8'hbb, 8'hbf};
    logic [7:0] latched [4] = '{8'h80, 8'h00, 8'h40, 8'h88};
    logic [15:0] d;
    int seed = 17;
    int n_mismatch = 0;
    int tests_run = 0;
    int n;

    // Core and link clocks, unrelated in phase
    always #2 clock = ~clock;
    initial begin
        #1.3;
        forever #3 link_clock = ~link_clock;
    end

    uvf_fault_handler #(.RETRY_UNIT_CYCLES(UNIT)) dut_u (.clock(clock), .reset(reset),
        .link_clock(link_clock), .link_req_valid(link_req_valid), .link_req(link_req),
        .link_busy(link_busy), .link_ans_valid(link_ans_valid), .link_ans(link_ans),
        .vin_measured(vin_measured), .undervoltage_lockout_strap(strap), .enable_pin(enable_pin),
        .write_protect(write_protect), .operation_on(operation_on),
        .other_fault_shutdown(other_fault_shutdown), .output_enable(output_enable),
        .alert_line_out(alert_line_out), .alert_line_oe_n(alert_line_oe_n));

    uvf_host_model host_u (.link_clock(link_clock), .link_busy(link_busy),
        .link_ans_valid(link_ans_valid), .link_ans(link_ans), .link_req_valid(link_req_valid),
        .link_req(link_req));

    // Linear-11 code of a voltage in quarter volts
    function automatic logic [15:0] l11(input int q);
        return {5'h1e, 11'(q)};
    endfunction

    // Cycles between fault and restart for an action byte
    function automatic int retry_cyc(input logic [7:0] act);
        return (int'(act[2:0]) + 1) * UNIT;
    endfunction

    task automatic test_done;
        $display("tests_run %0d n_mismatch %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_rng(input string what, input int lo, input int hi, input int g);
        tests_run++;
        if (g < lo || g > hi) begin
            n_mismatch++;
            $display("FAIL %s expected %0d..%0d seen %0d", what, lo, hi, g);
        end
    endtask

    // One register access through the host model
    task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] dv);
        bit ok;
        host_u.xfer({w, c, dv}, a, ok);
        if (!ok) begin
            n_mismatch++;
            $display("FAIL link answer expected 1 seen 0");
        end
    endtask

    task automatic set_vin(input int q);
        @(negedge clock);
        vin_measured = l11(q);
    endtask

    task automatic wait_oe(input logic v, input int maxc);
        n = 0;
        while (output_enable !== v && n < maxc) begin
            @(negedge clock);
            n++;
        end
    endtask

    // Input back above the warning limit, faults cleared, output running again
    task automatic recover;
        set_vin(40);
        acc(1'b1, UVF_CMD_CLEAR_FAULTS, 16'h0);
        wait_oe(1'b1, 300);
        chk("restart", 16'h1, {15'h0, output_enable});
    endtask

    initial begin
        vin_measured = l11(40);
        strap = l11(32);
        repeat (3) @(negedge clock);
        reset = 1'b0;
        repeat (6) @(negedge clock);
        acc(1'b0, UVF_CMD_FAULT_ACTION, 16'h0);
        chk("action reset", 16'h00bf, a.data);
        acc(1'b0, UVF_CMD_FAULT_THRESHOLD, 16'h0);
        chk("threshold reset", l11(32), a.data);
        acc(1'b0, UVF_CMD_WARN_LIMIT, 16'h0);
        chk("warning reset", l11(32), a.data);
        for (int i = 0; i < 3; i++) begin
            d = {5'h1e, 1'b0, 10'($random(seed))};
            acc(1'b1, UVF_CMD_FAULT_THRESHOLD, d);
            acc(1'b0, UVF_CMD_FAULT_THRESHOLD, 16'h0);
            chk("threshold", d, a.data);
        end
        @(negedge clock);
        write_protect = 1'b1;
        repeat (4) @(negedge clock);
        acc(1'b1, UVF_CMD_FAULT_THRESHOLD, l11(32));
        chk("protected write", 16'h1, {15'h0, a.refused});
        acc(1'b1, UVF_CMD_FAULT_ACTION, 16'h00c0);
        chk("protected write", 16'h1, {15'h0, a.refused});
        acc(1'b0, UVF_CMD_FAULT_THRESHOLD, 16'h0);
        chk("threshold kept", d, a.data);
        @(negedge clock);
        write_protect = 1'b0;
        repeat (4) @(negedge clock);
        acc(1'b0, 8'h20, 16'h0);
        chk("unmapped", 16'h1, {15'h0, a.refused});
        acc(1'b1, UVF_CMD_FAULT_THRESHOLD, l11(32));
        @(negedge clock);
        enable_pin = 1'b1;
        wait_oe(1'b1, 10);
        chk("running", 16'h1, {15'h0, output_enable});
        // Default action: retry only once above the warning limit
        set_vin(20 + ($random(seed) & 7));
        wait_oe(1'b0, 3);
        chk_rng("fault detect", 0, 2, n);
        chk("alert", 16'h0, {15'h0, alert_line_oe_n});
        chk("alert data", 16'h0, {15'h0, alert_line_out});
        acc(1'b0, UVF_CMD_STATUS_INPUT, 16'h0);
        chk("status", 16'h0010, a.data & 16'h0010);
        set_vin(35);
        repeat (retry_cyc(8'hbf) + 40) @(negedge clock);
        chk("below warning", 16'h0, {15'h0, output_enable});
        set_vin(36);
        wait_oe(1'b1, 4);
        chk("retry", 16'h1, {15'h0, output_enable});
        chk("alert sticky", 16'h0, {15'h0, alert_line_oe_n});
        recover();
        chk("alert cleared", 16'h1, {15'h0, alert_line_oe_n});
        acc(1'b0, UVF_CMD_STATUS_INPUT, 16'h0);
        chk("status cleared", 16'h0, a.data & 16'h0010);
        // Restart spacing follows the delay field
        foreach (spaced[i]) begin
            acc(1'b1, UVF_CMD_FAULT_ACTION, {8'h00, spaced[i]});
            set_vin(30);
            wait_oe(1'b0, 3);
            set_vin(40);
            wait_oe(1'b1, 400);
            chk_rng("retry spacing", retry_cyc(spaced[i]) - 3, retry_cyc(spaced[i]) + 3, n);
            recover();
        end
        // Off until input rises above the warning limit
        acc(1'b1, UVF_CMD_FAULT_ACTION, 16'h00c0);
        set_vin(30);
        wait_oe(1'b0, 3);
        set_vin(35);
        repeat (50) @(negedge clock);
        chk("hold under warning", 16'h0, {15'h0, output_enable});
        set_vin(36);
        wait_oe(1'b1, 4);
        chk("resume", 16'h1, {15'h0, output_enable});
        recover();
        // No retry and unused codes stay off until cleared
        foreach (latched[i]) begin
            acc(1'b1, UVF_CMD_FAULT_ACTION, {8'h00, latched[i]});
            set_vin(30);
            wait_oe(1'b0, 3);
            set_vin(40);
            repeat (300) @(negedge clock);
            chk("latched off", 16'h0, {15'h0, output_enable});
            recover();
        end
        // Commanded off ends continuous retry
        acc(1'b1, UVF_CMD_FAULT_ACTION, 16'h00bf);
        set_vin(30);
        wait_oe(1'b0, 3);
        enable_pin = 1'b0;
        set_vin(40);
        repeat (retry_cyc(8'hbf) + 50) @(negedge clock);
        chk("commanded off", 16'h0, {15'h0, output_enable});
        enable_pin = 1'b1;
        recover();
        @(negedge clock);
        other_fault_shutdown = 1'b1;
        wait_oe(1'b0, 3);
        chk("other fault off", 16'h0, {15'h0, output_enable});
        test_done();
    end

    // Watchdog against a hung handshake
    initial begin
        #200000;
        n_mismatch++;
        test_done();
    end
endmodule // tb_uvf_fault_handler
